// ===== rtl/simd_fp_exc_consts.svh
// offsets, field positions, reset values and event codes of the exception unit
`ifndef SIMD_FP_EXC_CONSTS_SVH
`define SIMD_FP_EXC_CONSTS_SVH
`define VCSR_OFFSET 12'h000
`define IRQ_STATUS_OFFSET 12'h004
`define IRQ_MASK_OFFSET 12'h008
`define CTRL_OFFSET 12'h00c
`define EXC_STATUS_OFFSET 12'h010
`define NUM_CLASSES 6
`define FLAG_LSB 0
`define MASK_LSB 7
`define CR4_OSX_BIT 10
`define VCSR_RESET 32'h0000_1f80
`define CTRL_RESET 32'h0000_0000
`define IRQ_MASK_RESET 32'h0000_0000
`define FLAG_FIELD 6'h3f
`define EV_XF 0
`define EV_UD 1
`define EV_NONNUM 2
`define NUM_EVENTS 3
`endif

// ===== rtl/simd_fp_exc_pkg.sv
// types shared by the exception unit files
`default_nettype none
package simd_fp_exc_pkg;
  typedef enum logic [1:0] {
    OP_PACKED_INT,
    OP_FP_SINGLE,
    OP_FP_DOUBLE,
    OP_X87_TRUNC_STORE
  } op_class_t;
  typedef enum logic [1:0] {
    RAISE_NONE,
    RAISE_SIMD_FP,
    RAISE_INVALID_OPCODE,
    RAISE_NON_NUMERIC
  } raise_t;
endpackage
`default_nettype wire

// ===== rtl/exc_class_filter.sv
// decides which exception kind a completing instruction raises
`include "simd_fp_exc_consts.svh"
`default_nettype none
module exc_class_filter #(
  parameter int NCLS = `NUM_CLASSES
) (
  input wire logic valid, // instruction completes
  input wire simd_fp_exc_pkg::op_class_t op_class, // kind of operation
  input wire logic [NCLS-1:0] cond, // conditions seen in any element
  input wire logic [NCLS-1:0] masks, // mask bits, one per class
  input wire logic os_support, // os handles simd fp exceptions
  input wire logic non_numeric, // fault of ordinary kind from the pipe
  output logic [NCLS-1:0] flag_set, // flags to set
  output simd_fp_exc_pkg::raise_t raise // resulting exception
);
  logic fp_op;
  logic [NCLS-1:0] unmasked;
  always_comb begin
    // integer ops and the truncating x87 store never touch vector fp flags
    fp_op = (op_class == simd_fp_exc_pkg::OP_FP_SINGLE) ||
            (op_class == simd_fp_exc_pkg::OP_FP_DOUBLE);
    flag_set = (valid && fp_op) ? cond : '0;
    unmasked = flag_set & ~masks;
    raise = simd_fp_exc_pkg::RAISE_NONE;
    if (valid && non_numeric) begin
      raise = simd_fp_exc_pkg::RAISE_NON_NUMERIC;
    end else if (|unmasked) begin
      raise = os_support ? simd_fp_exc_pkg::RAISE_SIMD_FP
                         : simd_fp_exc_pkg::RAISE_INVALID_OPCODE;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/simd_fp_exception_unit.sv
// vector floating-point exception unit with apb registers and interrupt
//
// Chosen here: the address map and the APB interface to the registers.
`include "simd_fp_exc_consts.svh"
`default_nettype none
module simd_fp_exception_unit #(
  parameter int NCLS = `NUM_CLASSES
) (
  input wire logic ref_clk, // core clock, 50 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic exec_done, // instruction completes this cycle
  input wire simd_fp_exc_pkg::op_class_t exec_op_class, // operation kind
  input wire logic [NCLS-1:0] exec_cond, // detected conditions, or of all elements
  input wire logic exec_non_numeric, // memory or other non-numeric fault
  input wire logic [31:0] exec_tag, // identifies the completing instruction
  input wire logic csr_load, // load or restore writes the status register
  input wire logic [31:0] csr_load_data, // value loaded
  input wire logic [31:0] control_register_4, // control register 4
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic [31:0] vector_ctrl_status_reg, // status register for store/save
  output logic simd_fp_exception_vector, // pulse: simd fp exception
  output logic invalid_opcode_exception, // pulse: invalid-opcode exception
  output logic non_numeric_exception, // pulse: non-numeric fault passed on
  output logic [31:0] exc_tag_out, // tag of faulting instruction
  output logic suppress_writeback, // pulse: keep operands and destination
  output logic irq // level interrupt
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] vcsr;
    logic [`NUM_EVENTS-1:0] irq_status;
    logic [`NUM_EVENTS-1:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic xf;
    logic ud;
    logic nn;
    logic [31:0] tag;
    logic suppress;
    logic irq;
    logic [1:0] last_raise;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [NCLS-1:0] flag_set;
  simd_fp_exc_pkg::raise_t raise;

  // ==========================================================
  // exception decision
  exc_class_filter #(.NCLS(NCLS)) u_filter (
    .valid(exec_done),
    .op_class(exec_op_class),
    .cond(exec_cond),
    .masks(state_reg.vcsr[`MASK_LSB +: NCLS]),
    .os_support(control_register_4[`CR4_OSX_BIT]),
    .non_numeric(exec_non_numeric),
    .flag_set(flag_set),
    .raise(raise)
  );

  function automatic logic [31:0] wmask(input logic [3:0] strb);
    wmask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic mapped;
  logic [31:0] be;
  logic [`NUM_EVENTS-1:0] ev;
  logic [`NUM_EVENTS-1:0] clr;

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    // answer one cycle into the access phase: its second cycle sees pready high
    apb_access = psel && penable && !state_reg.pready;
    apb_wr = apb_access && pwrite;
    apb_rd = apb_access && !pwrite;
    be = wmask(pstrb);
    mapped = (paddr == `VCSR_OFFSET) || (paddr == `IRQ_STATUS_OFFSET) ||
             (paddr == `IRQ_MASK_OFFSET) || (paddr == `CTRL_OFFSET) ||
             (paddr == `EXC_STATUS_OFFSET);
    ev = '0;
    clr = '0;
    state_next.pready = apb_access;
    state_next.pslverr = apb_access && !mapped;
    state_next.prdata = '0;
    if (apb_rd) begin
      case (paddr)
        `VCSR_OFFSET: state_next.prdata = state_reg.vcsr;
        `IRQ_STATUS_OFFSET: state_next.prdata = 32'(state_reg.irq_status);
        `IRQ_MASK_OFFSET: state_next.prdata = 32'(state_reg.irq_mask);
        `CTRL_OFFSET: state_next.prdata = control_register_4;
        `EXC_STATUS_OFFSET: state_next.prdata = {30'h0, state_reg.last_raise};
        default: state_next.prdata = '0;
      endcase
    end
    // software writes: load instruction port first, then apb
    if (csr_load) begin
      state_next.vcsr = csr_load_data;
    end else if (apb_wr && paddr == `VCSR_OFFSET) begin
      state_next.vcsr = (state_reg.vcsr & ~be) | (pwdata & be);
    end
    if (apb_wr && paddr == `IRQ_MASK_OFFSET) begin
      state_next.irq_mask = (state_reg.irq_mask & ~be[`NUM_EVENTS-1:0]) |
                            (pwdata[`NUM_EVENTS-1:0] & be[`NUM_EVENTS-1:0]);
    end
    if (apb_wr && paddr == `IRQ_STATUS_OFFSET) begin
      clr = pwdata[`NUM_EVENTS-1:0] & be[`NUM_EVENTS-1:0];
    end
    // hardware set wins over a same-cycle software write
    state_next.vcsr[`FLAG_LSB +: NCLS] = state_next.vcsr[`FLAG_LSB +: NCLS] |
                                         flag_set;
    // report in the completing cycle's next edge, tagged to that instruction
    state_next.xf = (raise == simd_fp_exc_pkg::RAISE_SIMD_FP);
    state_next.ud = (raise == simd_fp_exc_pkg::RAISE_INVALID_OPCODE);
    state_next.nn = (raise == simd_fp_exc_pkg::RAISE_NON_NUMERIC);
    state_next.suppress = (raise != simd_fp_exc_pkg::RAISE_NONE);
    if (raise != simd_fp_exc_pkg::RAISE_NONE) begin
      state_next.tag = exec_tag;
      state_next.last_raise = raise;
    end
    ev[`EV_XF] = state_next.xf;
    ev[`EV_UD] = state_next.ud;
    ev[`EV_NONNUM] = state_next.nn;
    state_next.irq_status = (state_reg.irq_status & ~clr) | ev;
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.vcsr <= `VCSR_RESET;
      state_reg.irq_mask <= `NUM_EVENTS'(`IRQ_MASK_RESET);
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign vector_ctrl_status_reg = state_reg.vcsr;
  assign simd_fp_exception_vector = state_reg.xf;
  assign invalid_opcode_exception = state_reg.ud;
  assign non_numeric_exception = state_reg.nn;
  assign exc_tag_out = state_reg.tag;
  assign suppress_writeback = state_reg.suppress;
  assign irq = state_reg.irq;
endmodule
`default_nettype wire

// ===== tb/simd_fp_exc_props.sv
// port assertions for the vector fp exception unit
`default_nettype none
module simd_fp_exc_props #(
  parameter int NCLS = 6
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic exec_done,
  input wire simd_fp_exc_pkg::op_class_t exec_op_class,
  input wire logic [NCLS-1:0] exec_cond,
  input wire logic exec_non_numeric,
  input wire logic [31:0] exec_tag,
  input wire logic csr_load,
  input wire logic [31:0] control_register_4,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [31:0] vector_ctrl_status_reg,
  input wire logic simd_fp_exception_vector,
  input wire logic invalid_opcode_exception,
  input wire logic non_numeric_exception,
  input wire logic [31:0] exc_tag_out,
  input wire logic suppress_writeback
);
  // ==========
  // assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic fp;
  logic hot;
  logic [NCLS-1:0] fl;
  // op codes 1 and 2 are the two floating-point kinds
  assign fp = exec_done && !exec_non_numeric && ^exec_op_class;
  assign hot = fp && |(exec_cond & ~vector_ctrl_status_reg[NCLS+6:7]);
  assign fl = vector_ctrl_status_reg[NCLS-1:0];
  a_simd_raise: assert property (hot && control_register_4[10] |=> simd_fp_exception_vector)
    else $error("simd fp exception missing");
  a_opcode_raise: assert property (hot && !control_register_4[10] |=>
    invalid_opcode_exception && !simd_fp_exception_vector) else $error("invalid opcode missing");
  a_int_quiet: assert property (exec_done && exec_op_class == 0 |=>
    !simd_fp_exception_vector && !invalid_opcode_exception) else $error("integer op raised");
  a_trunc_quiet: assert property (exec_done && &exec_op_class |=>
    !simd_fp_exception_vector && !invalid_opcode_exception) else $error("trunc store raised");
  a_fault_pass: assert property (exec_done && exec_non_numeric |=> non_numeric_exception)
    else $error("non-numeric fault lost");
  a_flag_sets: assert property (fp |=> (fl & $past(exec_cond)) == $past(exec_cond))
    else $error("flag not set");
  a_flag_sticky: assert property (!csr_load && !(psel && pwrite) |=>
    (fl & $past(fl)) == $past(fl)) else $error("flag cleared by hardware");
  a_tag_precise: assert property (simd_fp_exception_vector || invalid_opcode_exception |->
    exc_tag_out == $past(exec_tag)) else $error("tag not of completing instruction");
  a_keep_dest: assert property (simd_fp_exception_vector || invalid_opcode_exception |->
    suppress_writeback) else $error("writeback not suppressed");
endmodule
bind simd_fp_exception_unit simd_fp_exc_props #(.NCLS(NCLS)) u_props (.*);
`default_nettype wire

// ===== tb/exec_model.sv
// model of the execution units handing over completing instructions
`default_nettype none
module exec_model (
  input wire logic ref_clk, // core clock
  input wire logic go, // one completion this cycle
  input wire logic [1:0] op, // operation kind
  input wire logic [5:0] cond, // conditions
  input wire logic fault, // non-numeric fault
  output logic exec_done, // completes
  output simd_fp_exc_pkg::op_class_t exec_op_class, // kind
  output logic [5:0] exec_cond, // conditions
  output logic exec_non_numeric, // fault
  output logic [31:0] exec_tag // running id
);
  initial exec_tag = 32'h0;
  always @(posedge ref_clk) exec_tag <= exec_tag + 32'h1;
  // idle kind and conditions churn so a design that ignores exec_done shows it; the fault stays low when idle
  assign exec_done = go;
  assign exec_op_class = simd_fp_exc_pkg::op_class_t'(go ? op : exec_tag[1:0]);
  assign exec_cond = go ? cond : ~exec_tag[5:0];
  assign exec_non_numeric = go & fault;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the vector fp exception unit
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, sys_rst = 1'b1, go = 1'b0, fault = 1'b0, csr_load = 1'b0, err;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, suppress_writeback;
  logic simd_fp_exception_vector, invalid_opcode_exception, non_numeric_exception;
  logic exec_done, exec_non_numeric;
  simd_fp_exc_pkg::op_class_t exec_op_class;
  logic [1:0] op = 2'h0;
  logic [2:0] st = 3'h0;
  logic [3:0] pstrb = 4'hf;
  logic [5:0] cond = 6'h0, exec_cond, flags;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, csr_load_data = 32'h0, control_register_4 = 32'h0, rd;
  logic [31:0] prdata, vector_ctrl_status_reg, exec_tag, exc_tag_out;
  logic [31:0] tg = 32'h0;
  logic [1:0] lr = 2'h0;
  int miscompares = 0, checked = 0;
  always #10 ref_clk = ~ref_clk;
  exec_model u_exec (.*);
  simd_fp_exception_unit u_dut (.*);
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait states are the slave's; only the watchdog ends a hung wait
    do @(posedge ref_clk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // expected {fault, invalid opcode, simd fp}; faults take precedence
  function automatic logic [2:0] want(input logic [1:0] o, input logic [5:0] c, m,
                                      input logic f, os);
    if (f) return 3'b100;
    if (^o && |(c & ~m)) return os ? 3'b001 : 3'b010;
    return 3'b000;
  endfunction
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial begin
    logic [5:0] m, c;
    logic [1:0] o;
    logic [2:0] w;
    logic f, os;
    void'($urandom(32'h8a724b1e));
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("vcsr reset", 32'h0000_1f80, rd);
    apb(1'b1, 12'h014, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'hffff_ff00);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h0);
    chk("byte strobe", 32'h0000_1f00, rd);
    $display("reset test done");
    for (int i = 0; i < 60; i++) begin
      {o, c, os} = 9'($urandom);
      f = ($urandom % 5) == 0;
      if (f) c = 6'h0;
      if (i % 4 == 0) begin
        // first two loads unmask all so any fp condition raises
        m = (i < 8) ? 6'h0 : 6'($urandom);
        flags = 6'h0;
        @(posedge ref_clk);
        {csr_load, csr_load_data} <= {1'b1, 19'h0, m, 7'h0};
        @(posedge ref_clk);
        csr_load <= 1'b0;
      end
      @(posedge ref_clk);
      {go, op, cond, fault, control_register_4} <= {1'b1, o, c, f, 21'h0, os, 10'h0};
      @(posedge ref_clk);
      go <= 1'b0;
      @(negedge ref_clk);
      w = want(o, c, m, f, os);
      // tag was sampled one model count before the edge that raised
      if (|w) {tg, lr} = {exec_tag - 32'h1, w[2] ? 2'h3 : {w[1], w[0]}};
      if (^o && !f) flags = flags | c;
      chk("tag", tg, exc_tag_out);
      chk("suppress", {31'h0, |w}, {31'h0, suppress_writeback});
      chk("raise", {29'h0, want(o, c, m, f, os)}, {29'h0, non_numeric_exception,
          invalid_opcode_exception, simd_fp_exception_vector});
      chk("flags", {26'h0, flags}, {26'h0, vector_ctrl_status_reg[5:0]});
      chk("masks", {26'h0, m}, {26'h0, vector_ctrl_status_reg[12:7]});
      st = st | want(o, c, m, f, os);
    end
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("exception test done");
    apb(1'b1, 12'h008, 32'h7);
    repeat (2) @(negedge ref_clk);
    chk("irq raised", {31'h0, |st}, {31'h0, irq});
    apb(1'b0, 12'h004, 32'h0);
    chk("irq status", {29'h0, st}, rd);
    apb(1'b1, 12'h004, {29'h0, st});
    apb(1'b0, 12'h004, 32'h0);
    chk("irq cleared", 32'h0, rd);
    chk("irq low", 32'h0, {31'h0, irq});
    apb(1'b0, 12'h010, 32'h0);
    chk("last raise", {30'h0, lr}, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("cr4 mirror", control_register_4, rd);
    $display("interrupt test done");
    end_of_test();
  end
endmodule
`default_nettype wire
